// ### rtl/bwu_top.sv
// Breakpoint and watchpoint comparators with an APB register file.
//
// Overview of operation
// - Four instruction breakpoints with per-core masks.
// - Invert bit fires when PC differs.
// - Bit zero enables comparator, reset clear.
// - Four first range address registers.
// - Four second range address registers.
// - Data watchpoints carry per-core enable mask.
// - Stores are always evaluated.
// - Loads evaluated only with load bit.
// - Normal mode matches inclusive range.
// - Invert mode matches outside exclusive range.
// - Four resource mask registers.
// - Four resource compare value registers.
// - Resource watchpoints carry per-core enable mask.
// - Masked resource id equal triggers.
// - Invert mode triggers on inequality.
// - Any enabled hit raises debug interrupt.
// - Cause code three, four or five.
// - Simultaneous hits: instruction beats data, data beats resource; lowest numbered wins within one kind.
// - Capture data address or resource id on data or resource hit.
`timescale 1ns/1ps

module bwu_top #(
    parameter int NUM_CORES = 8
) (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    input  wire bwu_pkg::bwu_apb_req_t apb_req,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire bwu_pkg::bwu_fetch_t fetch,
    input  wire bwu_pkg::bwu_mem_t  mem,
    input  wire bwu_pkg::bwu_res_t  res,
    output logic                    dbg_irq,
    output logic [2:0]              dbg_cause,
    output logic [1:0]              dbg_index
);
    import bwu_pkg::*;

    // ****************************************
    // Parameter check.
    // ****************************************
    if (NUM_CORES != 8) begin : g_bad_cores
        $error("NUM_CORES must be 8 to fit the core mask field.");
    end

    // ****************************************
    // State.
    // ****************************************
    typedef struct packed {
        logic [3:0][31:0] ib_addr;
        logic [3:0][31:0] ib_ctrl;
        logic [3:0][31:0] dw_first;
        logic [3:0][31:0] dw_second;
        logic [3:0][31:0] dw_ctrl;
        logic [3:0][31:0] rw_mask;
        logic [3:0][31:0] rw_value;
        logic [3:0][31:0] rw_ctrl;
        logic [31:0]      cause;
        logic [31:0]      cause_data;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
    } bwu_state_t;

    bwu_state_t st_r;
    bwu_state_t st_nxt;
    logic [3:0] ib_hit;
    logic [3:0] dw_hit;
    logic [3:0] rw_hit;
    logic       in_range;
    logic       in_open;
    logic [7:0] idx;
    logic [1:0] sel;
    logic [5:0] grp;
    logic       map_ok;
    logic [31:0] rd_val;
    logic       wr_en;
    logic [31:0] wd;

    assign prdata    = st_r.prdata;
    assign pready    = st_r.pready;
    assign pslverr   = st_r.pslverr;
    assign dbg_irq   = st_r.irq;
    assign dbg_cause = st_r.cause[2:0];
    assign dbg_index = st_r.cause[CAUSE_IDX_LSB+1:CAUSE_IDX_LSB];

    // ****************************************
    // Comparators, register access and capture.
    // ****************************************
    always_comb begin
        st_nxt   = st_r;
        ib_hit   = 4'h0;
        dw_hit   = 4'h0;
        rw_hit   = 4'h0;
        in_range = 1'b0;
        in_open  = 1'b0;
        for (int i = 0; i < 4; i++) begin
            // Instruction breakpoints.
            if (fetch.valid && st_r.ib_ctrl[i][BIT_ENABLE]
                && st_r.ib_ctrl[i][CORE_MASK_LSB + fetch.core]) begin
                if (st_r.ib_ctrl[i][BIT_INVERT]) begin
                    ib_hit[i] = fetch.pc != st_r.ib_addr[i];
                end else begin
                    ib_hit[i] = fetch.pc == st_r.ib_addr[i];
                end
            end
            // Data watchpoints.
            in_range = mem.addr >= st_r.dw_first[i]
                       && mem.addr <= st_r.dw_second[i];
            in_open  = mem.addr > st_r.dw_first[i]
                       && mem.addr < st_r.dw_second[i];
            if (mem.valid && st_r.dw_ctrl[i][BIT_ENABLE]
                && st_r.dw_ctrl[i][CORE_MASK_LSB + mem.core]
                && (mem.store
                    || st_r.dw_ctrl[i][BIT_LOADS])) begin
                if (st_r.dw_ctrl[i][BIT_INVERT]) begin
                    dw_hit[i] = !in_open;
                end else begin
                    dw_hit[i] = in_range;
                end
            end
            // Resource watchpoints.
            if (res.valid && st_r.rw_ctrl[i][BIT_ENABLE]
                && st_r.rw_ctrl[i][CORE_MASK_LSB + res.core]) begin
                if (st_r.rw_ctrl[i][BIT_INVERT]) begin
                    rw_hit[i] = (res.id & st_r.rw_mask[i])
                                != st_r.rw_value[i];
                end else begin
                    rw_hit[i] = (res.id & st_r.rw_mask[i])
                                == st_r.rw_value[i];
                end
            end
        end

        // Register decode.
        idx    = apb_req.paddr[9:2];
        sel    = idx[1:0];
        grp    = idx[7:2];
        map_ok = apb_req.paddr[1:0] == 2'h0
                 && apb_req.paddr[PADDR_W-1:10] == 2'h0;
        rd_val = 32'h00000000;
        if (!map_ok) begin
            map_ok = 1'b0;
        end else if (grp == IDX_IB_ADDR[7:2]) begin
            rd_val = st_r.ib_addr[sel];
        end else if (grp == IDX_IB_CTRL[7:2]) begin
            rd_val = st_r.ib_ctrl[sel];
        end else if (grp == IDX_DW_FIRST[7:2]) begin
            rd_val = st_r.dw_first[sel];
        end else if (grp == IDX_DW_SECOND[7:2]) begin
            rd_val = st_r.dw_second[sel];
        end else if (grp == IDX_DW_CTRL[7:2]) begin
            rd_val = st_r.dw_ctrl[sel];
        end else if (grp == IDX_RW_MASK[7:2]) begin
            rd_val = st_r.rw_mask[sel];
        end else if (grp == IDX_RW_VALUE[7:2]) begin
            rd_val = st_r.rw_value[sel];
        end else if (grp == IDX_RW_CTRL[7:2]) begin
            rd_val = st_r.rw_ctrl[sel];
        end else if (idx == IDX_CAUSE) begin
            rd_val = st_r.cause;
        end else if (idx == IDX_CAUSE_DAT) begin
            rd_val = st_r.cause_data;
        end else begin
            map_ok = 1'b0;
        end

        // Answer one cycle after the setup phase.
        if (apb_req.psel && !apb_req.penable && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !map_ok;
            st_nxt.prdata  = apb_req.pwrite ? 32'h00000000 : rd_val;
        end else begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
        end

        // Writes land at the completing access edge.
        wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite
                && st_r.pready && map_ok;
        wd    = apb_req.pwdata;
        if (wr_en) begin
            if (grp == IDX_IB_ADDR[7:2]) begin
                st_nxt.ib_addr[sel] = wd;
            end else if (grp == IDX_IB_CTRL[7:2]) begin
                st_nxt.ib_ctrl[sel] = wd & IB_CTRL_WMASK;
            end else if (grp == IDX_DW_FIRST[7:2]) begin
                st_nxt.dw_first[sel] = wd;
            end else if (grp == IDX_DW_SECOND[7:2]) begin
                st_nxt.dw_second[sel] = wd;
            end else if (grp == IDX_DW_CTRL[7:2]) begin
                st_nxt.dw_ctrl[sel] = wd & DW_CTRL_WMASK;
            end else if (grp == IDX_RW_MASK[7:2]) begin
                st_nxt.rw_mask[sel] = wd;
            end else if (grp == IDX_RW_VALUE[7:2]) begin
                st_nxt.rw_value[sel] = wd;
            end else if (grp == IDX_RW_CTRL[7:2]) begin
                st_nxt.rw_ctrl[sel] = wd & RW_CTRL_WMASK;
            end else if (idx == IDX_CAUSE) begin
                st_nxt.cause = wd & CAUSE_WMASK;
            end else begin
                st_nxt.cause_data = wd;
            end
        end

        // Hit capture; a hit wins over a write in the same cycle.
        st_nxt.irq = |{ib_hit, dw_hit, rw_hit};
        for (int i = 3; i >= 0; i--) begin
            if (rw_hit[i] && ib_hit == 4'h0 && dw_hit == 4'h0) begin
                st_nxt.cause = {14'h0000, 2'(i), 5'h00, res.core,
                                5'h00, CAUSE_RES};
                st_nxt.cause_data = res.id;
            end
            if (dw_hit[i] && ib_hit == 4'h0) begin
                st_nxt.cause = {14'h0000, 2'(i), 5'h00, mem.core,
                                5'h00, CAUSE_DATA};
                st_nxt.cause_data = mem.addr;
            end
            if (ib_hit[i]) begin
                st_nxt.cause = {14'h0000, 2'(i), 5'h00, fetch.core,
                                5'h00, CAUSE_INSTR};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Assertions.
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    AST_IB_MASK: assert property (
        ib_hit[0] |-> st_r.ib_ctrl[0][CORE_MASK_LSB + fetch.core])
        else $error("Breakpoint fired for a masked core.");

    AST_IB_EQUAL: assert property (
        (fetch.valid && st_r.ib_ctrl[0][BIT_ENABLE]
         && !st_r.ib_ctrl[0][BIT_INVERT]
         && st_r.ib_ctrl[0][CORE_MASK_LSB + fetch.core]
         && fetch.pc == st_r.ib_addr[0]) |-> ib_hit[0])
        else $error("Equal breakpoint missed.");

    AST_IB_NOTEQ: assert property (
        (ib_hit[0] && st_r.ib_ctrl[0][BIT_INVERT])
        |-> fetch.pc != st_r.ib_addr[0])
        else $error("Inverted breakpoint fired on equality.");

    AST_DW_ENABLE: assert property (
        !st_r.dw_ctrl[0][BIT_ENABLE] |-> !dw_hit[0])
        else $error("Disabled watchpoint fired.");

    AST_DW_LOADS: assert property (
        (dw_hit[0] && !mem.store) |-> st_r.dw_ctrl[0][BIT_LOADS])
        else $error("Load triggered without load enable.");

    AST_DW_RANGE: assert property (
        (dw_hit[0] && !st_r.dw_ctrl[0][BIT_INVERT])
        |-> (mem.addr >= st_r.dw_first[0]
             && mem.addr <= st_r.dw_second[0]))
        else $error("Inclusive range hit outside range.");

    AST_RW_EQUAL: assert property (
        (rw_hit[0] && !st_r.rw_ctrl[0][BIT_INVERT])
        |-> (res.id & st_r.rw_mask[0]) == st_r.rw_value[0])
        else $error("Resource hit without masked match.");

    AST_IRQ_INSTR: assert property (
        (clk_en && ib_hit != 4'h0)
        |=> (dbg_irq && dbg_cause == CAUSE_INSTR))
        else $error("Instruction hit did not raise cause three.");

    AST_DATA_CAPT: assert property (
        (clk_en && dw_hit != 4'h0 && ib_hit == 4'h0)
        |=> (st_r.cause_data == $past(mem.addr)
             && dbg_cause == CAUSE_DATA))
        else $error("Data hit address not captured.");

    AST_LOWEST: assert property (
        (clk_en && ib_hit[0] && ib_hit[1]) |=> dbg_index == 2'h0)
        else $error("Lowest breakpoint not reported.");

    AST_RW_ENABLE: assert property (
        !st_r.rw_ctrl[0][BIT_ENABLE] |-> !rw_hit[0])
        else $error("Disabled resource watchpoint fired.");

    AST_DW_MASK: assert property (
        dw_hit[0] |-> st_r.dw_ctrl[0][CORE_MASK_LSB + mem.core])
        else $error("Watchpoint fired for a masked core.");

    AST_DW_STORE: assert property (
        (mem.valid && mem.store && st_r.dw_ctrl[0][BIT_ENABLE]
         && !st_r.dw_ctrl[0][BIT_INVERT]
         && st_r.dw_ctrl[0][CORE_MASK_LSB + mem.core]
         && mem.addr >= st_r.dw_first[0]
         && mem.addr <= st_r.dw_second[0]) |-> dw_hit[0])
        else $error("Store inside an enabled range missed.");

    AST_DW_OUTSIDE: assert property (
        (dw_hit[0] && st_r.dw_ctrl[0][BIT_INVERT])
        |-> (mem.addr <= st_r.dw_first[0]
             || mem.addr >= st_r.dw_second[0]))
        else $error("Exclusive range hit inside range.");

    AST_RW_MASK: assert property (
        rw_hit[0] |-> st_r.rw_ctrl[0][CORE_MASK_LSB + res.core])
        else $error("Resource watchpoint fired for a masked core.");

    AST_RW_NOTEQ: assert property (
        (rw_hit[0] && st_r.rw_ctrl[0][BIT_INVERT])
        |-> (res.id & st_r.rw_mask[0]) != st_r.rw_value[0])
        else $error("Inverted resource hit on a masked match.");

    AST_RES_CAPT: assert property (
        (clk_en && rw_hit != 4'h0 && ib_hit == 4'h0 && dw_hit == 4'h0)
        |=> (st_r.cause_data == $past(res.id)
             && dbg_cause == CAUSE_RES))
        else $error("Resource hit identifier not captured.");

    AST_RESERVED: assert property (
        (st_r.ib_ctrl[0] & ~IB_CTRL_WMASK) == 32'h00000000
        && (st_r.dw_ctrl[0] & ~DW_CTRL_WMASK) == 32'h00000000
        && (st_r.rw_ctrl[0] & ~RW_CTRL_WMASK) == 32'h00000000)
        else $error("Reserved control bits are set.");

    AST_IRQ_NONE: assert property (
        (clk_en && {ib_hit, dw_hit, rw_hit} == 12'h000) |=> !dbg_irq)
        else $error("Debug interrupt without a hit.");

endmodule

// ### inc/bwu_pkg.sv
// Constants and carrier types for the breakpoint and watchpoint unit.
package bwu_pkg;

    // ****************************************
    // Register indices (byte address is four times the index).
    // ****************************************
    localparam logic [7:0]  IDX_IB_ADDR   = 8'h30;
    localparam logic [7:0]  IDX_IB_CTRL   = 8'h40;
    localparam logic [7:0]  IDX_DW_FIRST  = 8'h50;
    localparam logic [7:0]  IDX_DW_SECOND = 8'h60;
    localparam logic [7:0]  IDX_DW_CTRL   = 8'h70;
    localparam logic [7:0]  IDX_RW_MASK   = 8'h80;
    localparam logic [7:0]  IDX_RW_VALUE  = 8'h90;
    localparam logic [7:0]  IDX_RW_CTRL   = 8'h9C;
    localparam logic [7:0]  IDX_CAUSE     = 8'h15;
    localparam logic [7:0]  IDX_CAUSE_DAT = 8'h16;

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int          BIT_ENABLE    = 0;
    localparam int          BIT_INVERT    = 1;
    localparam int          BIT_LOADS     = 2;
    localparam int          CORE_MASK_LSB = 16;
    localparam int          CAUSE_IDX_LSB = 16;
    localparam int          CAUSE_CORE_LSB = 8;

    // ****************************************
    // Writable bits and reset values.
    // ****************************************
    localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF0007;
    localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] CAUSE_WMASK   = 32'h0003FF07;
    localparam logic [31:0] REG_RESET     = 32'h00000000;

    // ****************************************
    // Debug interrupt cause codes.
    // ****************************************
    localparam logic [2:0]  CAUSE_INSTR   = 3'h3;
    localparam logic [2:0]  CAUSE_DATA    = 3'h4;
    localparam logic [2:0]  CAUSE_RES     = 3'h5;

    localparam int          PADDR_W       = 12;

    typedef struct packed {
        logic        valid;
        logic [2:0]  core;
        logic [31:0] pc;
    } bwu_fetch_t;

    typedef struct packed {
        logic        valid;
        logic        store;
        logic [2:0]  core;
        logic [31:0] addr;
    } bwu_mem_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  core;
        logic [31:0] id;
    } bwu_res_t;

    typedef struct packed {
        logic [PADDR_W-1:0] paddr;
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [31:0]        pwdata;
    } bwu_apb_req_t;

endpackage

// ### tb/bwu_core_model.sv
// Core-side model that issues fetch, memory and resource events.
`timescale 1ns/1ps
module bwu_core_model (
    input  wire logic                sys_clk,
    input  wire logic [2:0]          issue,
    input  wire bwu_pkg::bwu_fetch_t f_in,
    input  wire bwu_pkg::bwu_mem_t   m_in,
    input  wire bwu_pkg::bwu_res_t   r_in,
    output bwu_pkg::bwu_fetch_t      fetch,
    output bwu_pkg::bwu_mem_t        mem,
    output bwu_pkg::bwu_res_t        res
);
    import bwu_pkg::*;

    bwu_fetch_t fetch_q = '0;
    bwu_mem_t   mem_q   = '0;
    bwu_res_t   res_q   = '0;

    assign fetch = fetch_q;
    assign mem   = mem_q;
    assign res   = res_q;

    // Each event stands one cycle; idle cycles show a changing payload.
    always @(posedge sys_clk) begin
        fetch_q <= issue[0] ? {1'b1, f_in[34:0]}
                            : {1'b0, ~fetch_q[34:0]};
        mem_q   <= issue[1] ? {1'b1, m_in[35:0]}
                            : {1'b0, ~mem_q[35:0]};
        res_q   <= issue[2] ? {1'b1, r_in[34:0]}
                            : {1'b0, ~res_q[34:0]};
    end
endmodule

// ### tb/bwu_bench.sv
// Self-checking bench for the breakpoint and watchpoint unit.
`timescale 1ns/1ps
module bwu_bench;
    import bwu_pkg::*;

    logic         sys_clk = 1'b0;
    logic         reset = 1'b1;
    logic         clk_en = 1'b1;
    logic [2:0]   issue = '0;
    bwu_apb_req_t apb = '0;
    bwu_fetch_t   fetch;
    bwu_fetch_t   f_in = '0;
    bwu_mem_t     mem;
    bwu_mem_t     m_in = '0;
    bwu_res_t     res;
    bwu_res_t     r_in = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         dbg_irq;
    logic [2:0]   dbg_cause;
    logic [1:0]   dbg_index;
    int           bad_count = 0;
    int           samples_checked = 0;
    logic [31:0]  rd, a, f, s, ad, c, m, v;
    logic [2:0]   core;
    logic [1:0]   i;
    logic         err, st, h;
    logic [7:0]   regs [5] = '{IDX_IB_ADDR, IDX_DW_FIRST, IDX_DW_SECOND,
                               IDX_RW_MASK, IDX_RW_VALUE};

    always #20 sys_clk = ~sys_clk;

    bwu_top bwu_top_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .apb_req(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetch(fetch), .mem(mem), .res(res), .dbg_irq(dbg_irq),
        .dbg_cause(dbg_cause), .dbg_index(dbg_index));
    bwu_core_model bwu_core_model_inst (.sys_clk(sys_clk), .issue(issue),
        .f_in(f_in), .m_in(m_in), .r_in(r_in), .fetch(fetch), .mem(mem),
        .res(res));

    // ****************************************
    // Checking, bus and event tasks.
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd);
        apb <= '{paddr: {2'b00, idx, 2'b00}, psel: 1'b1, penable: 1'b0,
                 pwrite: wr, pwdata: wd};
        @(posedge sys_clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_expect(input string what, input logic [7:0] idx,
                             input logic [31:0] exp);
        xfer(1'b0, idx, '0);
        check(what, rd, exp);
    endtask

    task automatic fire(input logic [2:0] k, input logic hit,
                        input logic [2:0] cause, input logic [1:0] idx);
        issue <= k;
        @(posedge sys_clk);
        issue <= '0;
        @(posedge sys_clk);
        #1;
        check("irq", dbg_irq, hit);
        if (hit) begin
            check("cause", dbg_cause, cause);
            check("index", dbg_index, idx);
        end
        @(posedge sys_clk);
        #1;
        check("pulse", dbg_irq, 32'h0);
        @(posedge sys_clk);
    endtask

    function automatic logic sel(logic [31:0] cc, logic [2:0] cr);
        return cc[BIT_ENABLE] && cc[CORE_MASK_LSB + cr];
    endfunction

    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        rd = $urandom(87);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            rd_expect("ib_ctrl", IDX_IB_CTRL + 8'(k), 32'h0);
            rd_expect("dw_ctrl", IDX_DW_CTRL + 8'(k), 32'h0);
            rd_expect("rw_ctrl", IDX_RW_CTRL + 8'(k), 32'h0);
            xfer(1'b1, IDX_IB_CTRL + 8'(k), 32'hFFFFFFFF);
            rd_expect("ib_res", IDX_IB_CTRL + 8'(k), IB_CTRL_WMASK);
            xfer(1'b1, IDX_DW_CTRL + 8'(k), 32'hFFFFFFFF);
            rd_expect("dw_res", IDX_DW_CTRL + 8'(k), DW_CTRL_WMASK);
            xfer(1'b1, IDX_RW_CTRL + 8'(k), 32'hFFFFFFFF);
            rd_expect("rw_res", IDX_RW_CTRL + 8'(k), RW_CTRL_WMASK);
            xfer(1'b1, IDX_IB_CTRL + 8'(k), 32'h0);
            xfer(1'b1, IDX_DW_CTRL + 8'(k), 32'h0);
            xfer(1'b1, IDX_RW_CTRL + 8'(k), 32'h0);
            foreach (regs[r]) begin
                a = $urandom;
                xfer(1'b1, regs[r] + 8'(k), a);
                rd_expect("word", regs[r] + 8'(k), a);
            end
        end
        xfer(1'b0, 8'h20, '0);
        check("unmapped_err", err, 32'h1);
        check("unmapped_data", rd, 32'h0);
        repeat (40) begin
            i = 2'($urandom);
            a = $urandom;
            c = $urandom & IB_CTRL_WMASK;
            c[0] = ($urandom % 4) != 0;
            core = 3'($urandom);
            f_in <= {1'b1, core, ($urandom % 2) ? a : 32'($urandom)};
            xfer(1'b1, IDX_IB_ADDR + i, a);
            xfer(1'b1, IDX_IB_CTRL + i, c);
            h = sel(c, core) && (c[1] ? f_in.pc != a : f_in.pc == a);
            fire(3'b001, h, CAUSE_INSTR, i);
            xfer(1'b1, IDX_IB_CTRL + i, 32'h0);
        end
        repeat (40) begin
            i = 2'($urandom);
            f = $urandom >> 1;
            s = f + ($urandom % 64);
            case ($urandom % 6)
                0: ad = f;
                1: ad = s;
                2: ad = f - 1;
                3: ad = s + 1;
                4: ad = f + ($urandom % (s - f + 1));
                default: ad = $urandom;
            endcase
            c = $urandom & DW_CTRL_WMASK;
            c[0] = ($urandom % 4) != 0;
            core = 3'($urandom);
            st = 1'($urandom);
            m_in <= {1'b1, st, core, ad};
            xfer(1'b1, IDX_DW_FIRST + i, f);
            xfer(1'b1, IDX_DW_SECOND + i, s);
            xfer(1'b1, IDX_DW_CTRL + i, c);
            h = sel(c, core) && (st || c[BIT_LOADS]) && (c[1] ?
                (ad <= f || ad >= s) : (ad >= f && ad <= s));
            fire(3'b010, h, CAUSE_DATA, i);
            if (h) rd_expect("addr_cap", IDX_CAUSE_DAT, ad);
            xfer(1'b1, IDX_DW_CTRL + i, 32'h0);
        end
        repeat (40) begin
            i = 2'($urandom);
            m = $urandom;
            v = $urandom & m;
            ad = ($urandom % 2) ? (v | (~m & $urandom)) : $urandom;
            c = $urandom & RW_CTRL_WMASK;
            c[0] = ($urandom % 4) != 0;
            core = 3'($urandom);
            r_in <= {1'b1, core, ad};
            xfer(1'b1, IDX_RW_MASK + i, m);
            xfer(1'b1, IDX_RW_VALUE + i, v);
            xfer(1'b1, IDX_RW_CTRL + i, c);
            h = sel(c, core) && (c[1] ? (ad & m) != v : (ad & m) == v);
            fire(3'b100, h, CAUSE_RES, i);
            if (h) rd_expect("id_cap", IDX_CAUSE_DAT, ad);
            xfer(1'b1, IDX_RW_CTRL + i, 32'h0);
        end
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, IDX_IB_ADDR + 8'(k), 32'h00000100);
            xfer(1'b1, IDX_IB_CTRL + 8'(k), 32'h00FF0001);
        end
        xfer(1'b1, IDX_DW_FIRST, 32'h0);
        xfer(1'b1, IDX_DW_SECOND, 32'hFFFFFFFF);
        xfer(1'b1, IDX_DW_CTRL, 32'h00FF0001);
        f_in <= {1'b1, 3'h5, 32'h00000100};
        m_in <= {1'b1, 1'b1, 3'h2, 32'h00001000};
        fire(3'b011, 1'b1, CAUSE_INSTR, 2'h0);
        clk_en <= 1'b0;
        fire(3'b001, 1'b0, CAUSE_INSTR, 2'h0);
        clk_en <= 1'b1;
        rd_expect("cause", IDX_CAUSE, 32'h00000503);
        finish_test();
    end

    initial begin
        #(40 * 20000);
        bad_count++;
        finish_test();
    end
endmodule
